/* shared/tevc_defs.svh */
// constants for the thermal event output control block
`ifndef TEVC_DEFS_SVH
`define TEVC_DEFS_SVH
`define TEVC_CFG_W          16
`define TEVC_BIT_MODE       0
`define TEVC_BIT_POL        1
`define TEVC_BIT_CRIT_ONLY  2
`define TEVC_BIT_OUT_EN     3
`define TEVC_BIT_ASSERTED   4
`define TEVC_BIT_CLEAR      5
`define TEVC_CFG_RESET      16'h0000
`endif

/* shared/tevc_pkg.sv */
// types for the thermal event output control block
package tevc_pkg;
    // effective settings applied to the output
    typedef struct packed {
        logic out_en;
        logic crit_only;
        logic pol;
        logic mode;
    } tevc_ctl_t;

    // trip conditions from the comparator core
    typedef struct packed {
        logic crit;
        logic window;
    } tevc_trip_t;

    typedef enum logic [1:0] {
        TEVC_RUN   = 2'b01,
        TEVC_SLEEP = 2'b10
    } tevc_state_t;
endpackage

/* logic/tevc_event_ctl.sv */
// event output control: configuration bits, locks, shutdown behaviour, alert pin
//
// Contract
// - critical-only gate selects crit or any event
// - alarm lock blocks critical-only writes
// - polarity bit zero gives active low
// - either lock blocks polarity writes
// - polarity change drives pin immediately
// - sleep holds pin or deasserts it
// - other shutdown writes apply after conversion
// - some bus options defer polarity in shutdown
// - mode bit selects comparator or interrupt
// - either lock blocks mode writes
// - output enable zero keeps pin released
// - interrupt event latched until software clears
`timescale 1ns/1ns
`include "tevc_defs.svh"
module tevc_event_ctl (
    input  wire logic                    i_clk,
    input  wire logic                    i_reset,
    input  wire logic                    i_cfg_wr,
    input  wire logic [`TEVC_CFG_W-1:0]  i_cfg_wdata,
    output logic      [`TEVC_CFG_W-1:0]  o_cfg_rdata,
    input  wire logic                    i_lock_crit,
    input  wire logic                    i_lock_alarm,
    input  wire tevc_pkg::tevc_trip_t    i_trip,
    input  wire logic                    i_conv_done,
    input  wire logic                    i_shutdown,
    input  wire logic                    i_sleep_alert_state,
    input  wire logic                    i_timeout_disable,
    input  wire logic                    i_data_line_enable,
    input  wire logic                    i_alert_response,
    output logic                         o_alert,
    output logic                         o_alert_oe_n,
    output logic                         o_alert_asserted_flag
);
    tevc_pkg::tevc_ctl_t   prog_r;
    tevc_pkg::tevc_ctl_t   eff_r;
    tevc_pkg::tevc_state_t state_r;
    logic                  pend_r;
    logic                  latch_r;
    logic                  frozen_r;
    logic                  active_r;
    logic                  any_lock;
    logic                  cond;
    logic                  pol_defer;
    logic                  raw_active;
    logic                  clr;

    assign any_lock  = i_lock_crit | i_lock_alarm;
    // polarity deferral depends on the bus options
    assign pol_defer = i_timeout_disable | ~i_data_line_enable;
    assign clr       = (i_cfg_wr & i_cfg_wdata[`TEVC_BIT_CLEAR]) | i_alert_response;

    // programmed bits, each write gated by its locks
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            prog_r <= '0;
        end else if (i_cfg_wr) begin
            if (!i_lock_alarm) begin
                prog_r.crit_only <= i_cfg_wdata[`TEVC_BIT_CRIT_ONLY];
            end
            if (!any_lock) begin
                prog_r.pol    <= i_cfg_wdata[`TEVC_BIT_POL];
                prog_r.mode   <= i_cfg_wdata[`TEVC_BIT_MODE];
                prog_r.out_en <= i_cfg_wdata[`TEVC_BIT_OUT_EN];
            end
        end
    end

    // run/sleep tracking; pend marks waiting for first conversion after wake
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= tevc_pkg::TEVC_RUN;
            pend_r  <= 1'b0;
        end else begin
            case (state_r)
                tevc_pkg::TEVC_RUN: begin
                    if (i_shutdown) begin
                        state_r <= tevc_pkg::TEVC_SLEEP;
                    end else if (i_conv_done) begin
                        pend_r <= 1'b0;
                    end
                end
                tevc_pkg::TEVC_SLEEP: begin
                    if (!i_shutdown) begin
                        state_r <= tevc_pkg::TEVC_RUN;
                        pend_r  <= 1'b1;
                    end
                end
                default: begin
                    state_r <= tevc_pkg::TEVC_RUN;
                end
            endcase
        end
    end

    // effective settings: shutdown edits other than polarity held until a fresh conversion
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            eff_r <= '0;
        end else begin
            if (state_r == tevc_pkg::TEVC_RUN && !pend_r && !i_shutdown) begin
                eff_r.mode      <= prog_r.mode;
                eff_r.crit_only <= prog_r.crit_only;
                eff_r.out_en    <= prog_r.out_en;
            end else if (state_r == tevc_pkg::TEVC_RUN && pend_r && i_conv_done) begin
                eff_r.mode      <= prog_r.mode;
                eff_r.crit_only <= prog_r.crit_only;
                eff_r.out_en    <= prog_r.out_en;
            end
            // polarity bypasses conversion timing unless options defer it
            if (state_r == tevc_pkg::TEVC_RUN || !pol_defer) begin
                eff_r.pol <= prog_r.pol;
            end
        end
    end

    // trip selection by the critical-only gate
    assign cond = eff_r.crit_only ? i_trip.crit : (i_trip.crit | i_trip.window);

    // interrupt latch; a new event beats a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            latch_r <= 1'b0;
        end else if (state_r == tevc_pkg::TEVC_RUN && eff_r.mode && cond) begin
            latch_r <= 1'b1;
        end else if (clr || !eff_r.mode) begin
            latch_r <= 1'b0;
        end
    end

    // comparator follows condition, interrupt shows latch
    assign raw_active = eff_r.mode ? latch_r : cond;

    // asserted state, frozen or cleared in sleep
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            active_r <= 1'b0;
            frozen_r <= 1'b0;
        end else if (state_r == tevc_pkg::TEVC_SLEEP) begin
            active_r <= i_sleep_alert_state ? 1'b0 : frozen_r;
        end else begin
            active_r <= raw_active & eff_r.out_en;
            frozen_r <= raw_active & eff_r.out_en;
        end
    end

    // pin level mapped by polarity combinationally so a polarity change is instant
    always_comb begin
        o_alert      = eff_r.pol ? active_r : ~active_r;
        o_alert_oe_n = ~eff_r.out_en;
    end

    assign o_alert_asserted_flag = active_r;
    // upper bits read as zero; clear bit is write-only and reads zero too
    assign o_cfg_rdata = {11'h000, active_r, prog_r.out_en, prog_r.crit_only, prog_r.pol, prog_r.mode};

    // assertions
    a_crit_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == tevc_pkg::TEVC_RUN && !eff_r.mode && eff_r.crit_only && !i_trip.crit) |=> !active_r)
        else $error("window event passed the critical-only gate");
    a_crit_lock: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_cfg_wr && i_lock_alarm) |=> prog_r.crit_only == $past(prog_r.crit_only))
        else $error("critical-only not held");
    a_pol_lock: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_cfg_wr && any_lock) |=> $stable(prog_r.pol))
        else $error("polarity changed under lock");
    a_mode_lock: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_cfg_wr && any_lock) |=> $stable(prog_r.mode))
        else $error("mode changed under lock");
    a_polarity: assert property (@(posedge i_clk) disable iff (i_reset)
        o_alert_asserted_flag |-> o_alert == eff_r.pol)
        else $error("asserted alert level wrong for polarity");
    a_pol_apply: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == tevc_pkg::TEVC_RUN || !pol_defer) |=> eff_r.pol == $past(prog_r.pol))
        else $error("polarity not applied at once");
    a_disabled: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == tevc_pkg::TEVC_RUN && !eff_r.out_en) |=> !active_r)
        else $error("alert asserted while disabled");
    a_sleep_deassert: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == tevc_pkg::TEVC_SLEEP && i_sleep_alert_state) |=> !active_r)
        else $error("alert not deasserted in sleep");
    a_pol_defer: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == tevc_pkg::TEVC_SLEEP && pol_defer) |=> $stable(eff_r.pol))
        else $error("polarity applied in sleep despite deferral");
    a_comp_follow: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == tevc_pkg::TEVC_RUN && !eff_r.mode && eff_r.out_en && cond) |=> active_r)
        else $error("comparator output did not follow trip");
    a_latch_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        (latch_r && eff_r.mode && !clr) |=> latch_r)
        else $error("interrupt latch dropped without clear");
endmodule

/* dv/tevc_host.sv */
// host-side model that writes the configuration word
`timescale 1ns/1ns
module tevc_host (
    input  wire logic        i_clk,
    output logic             o_cfg_wr,
    output logic [15:0]      o_cfg_wdata
);
    // idle data shows a pattern, never the word last written
    initial begin
        o_cfg_wr = 1'h0;
        o_cfg_wdata = 16'h5a5a;
    end
    // one-cycle strobe; caller enters just after a falling edge
    task automatic wr(input logic [15:0] d);
        o_cfg_wr = 1'h1;
        o_cfg_wdata = d;
        @(negedge i_clk);
        o_cfg_wr = 1'h0;
        o_cfg_wdata = ~d;
    endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the event output control block
`timescale 1ns/1ns
module testbench;
    logic                 clk;
    logic                 rst;
    logic                 wr;
    logic [15:0]          wd;
    logic [15:0]          rd;
    logic                 lk_c;
    logic                 lk_a;
    logic                 sd;
    logic                 slp;
    logic                 tod;
    logic                 dle;
    logic                 cd;
    logic                 ar;
    tevc_pkg::tevc_trip_t trip;
    logic                 alert;
    logic                 oe_n;
    logic                 flag;
    int                   bad_count = 0;
    int                   tests_run = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    tevc_host host (.i_clk(clk), .o_cfg_wr(wr), .o_cfg_wdata(wd));
    tevc_event_ctl DUT (.i_clk(clk), .i_reset(rst), .i_cfg_wr(wr), .i_cfg_wdata(wd), .o_cfg_rdata(rd),
        .i_lock_crit(lk_c), .i_lock_alarm(lk_a), .i_trip(trip), .i_conv_done(cd), .i_shutdown(sd),
        .i_sleep_alert_state(slp), .i_timeout_disable(tod), .i_data_line_enable(dle),
        .i_alert_response(ar), .o_alert(alert), .o_alert_oe_n(oe_n), .o_alert_asserted_flag(flag));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pins(input logic a, input logic o, input logic f);
        chk({13'h0000, alert, oe_n, flag}, {13'h0000, a, o, f});
    endtask
    task automatic t_reset;
        pins(1'h1, 1'h1, 1'h0);
        chk(rd, 16'h0000);
    endtask
    task automatic t_comp;
        host.wr(16'h0008);
        trip = 2'h1;
        w(4);
        pins(1'h0, 1'h0, 1'h1);
        trip = 2'h0;
        w(4);
        pins(1'h1, 1'h0, 1'h0);
    endtask
    task automatic t_pol;
        host.wr(16'h000a);
        w(4);
        pins(1'h0, 1'h0, 1'h0);
        trip = 2'h1;
        w(4);
        pins(1'h1, 1'h0, 1'h1);
        trip = 2'h0;
        w(4);
    endtask
    task automatic t_crit;
        host.wr(16'h000c);
        trip = 2'h1;
        w(4);
        pins(1'h1, 1'h0, 1'h0);
        trip = 2'h2;
        w(4);
        pins(1'h0, 1'h0, 1'h1);
        trip = 2'h0;
        w(4);
    endtask
    // either lock freezes mode and polarity, only the alarm lock freezes the gate
    task automatic t_lock;
        lk_c = 1'h1;
        host.wr(16'h0003);
        w(2);
        chk(rd, 16'h0008);
        lk_c = 1'h0;
        lk_a = 1'h1;
        host.wr(16'h000c);
        w(2);
        chk(rd, 16'h0008);
        lk_a = 1'h0;
    endtask
    task automatic t_irq;
        host.wr(16'h0009);
        trip = 2'h1;
        w(4);
        trip = 2'h0;
        w(4);
        pins(1'h0, 1'h0, 1'h1);
        ar = 1'h1;
        w(1);
        ar = 1'h0;
        w(4);
        pins(1'h1, 1'h0, 1'h0);
        trip = 2'h1;
        w(2);
        trip = 2'h0;
        w(2);
        pins(1'h0, 1'h0, 1'h1);
        host.wr(16'h0029);
        w(4);
        pins(1'h1, 1'h0, 1'h0);
    endtask
    // shutdown: deassert or freeze, instant or deferred polarity, gate held until a conversion
    task automatic t_sleep;
        host.wr(16'h0008);
        trip = 2'h1;
        w(4);
        pins(1'h0, 1'h0, 1'h1);
        slp = 1'h1;
        sd = 1'h1;
        w(4);
        pins(1'h1, 1'h0, 1'h0);
        host.wr(16'h000e);
        w(2);
        pins(1'h0, 1'h0, 1'h0);
        sd = 1'h0;
        w(3);
        pins(1'h1, 1'h0, 1'h1);
        cd = 1'h1;
        w(1);
        cd = 1'h0;
        w(3);
        pins(1'h0, 1'h0, 1'h0);
        trip = 2'h2;
        w(2);
        slp = 1'h0;
        sd = 1'h1;
        w(2);
        trip = 2'h0;
        w(4);
        pins(1'h1, 1'h0, 1'h1);
        tod = 1'h1;
        host.wr(16'h000c);
        w(2);
        pins(1'h1, 1'h0, 1'h1);
        tod = 1'h0;
        dle = 1'h0;
        w(2);
        pins(1'h1, 1'h0, 1'h1);
        trip = 2'h2;
        sd = 1'h0;
        w(4);
        pins(1'h0, 1'h0, 1'h1);
        dle = 1'h1;
        trip = 2'h0;
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence; reset held twenty cycles
    initial begin
        clk = 1'h0;
        rst = 1'h1;
        lk_c = 1'h0;
        lk_a = 1'h0;
        sd = 1'h0;
        slp = 1'h0;
        tod = 1'h0;
        dle = 1'h1;
        cd = 1'h0;
        ar = 1'h0;
        trip = 2'h0;
        w(20);
        rst = 1'h0;
        w(1);
        t_reset();
        t_comp();
        t_pol();
        t_crit();
        t_lock();
        t_irq();
        t_sleep();
        end_sim();
    end
    // watchdog, well past the expected run of about 120 cycles
    initial begin
        #40000;
        bad_count++;
        end_sim();
    end
endmodule
